//--- hw/pao_converter.sv
// Purpose: digital side of a 10-bit pipelined converter
// Assumes: analog_in is the held input level, on the clk domain
// Notes:   stages are modelled as integer residue arithmetic
//
// Behaviour
// R1: two non-overlapping phases from master clock
// R2: sample on phase fall, transfer in amplify
// R3: nine two-bit stages plus one-bit stage
// R4: adjacent stages clocked half period apart
// R5: delay line aligns stage results per sample
// R6: redundant-bit correction gives one 10-bit code
// R7: code appears at seventh master clock
// R8: one new word every master clock
// R9: two cascaded registers drive output bus
// R10: format select low binary, high complement
// R11: first 20 words after power-up discarded
// R12: master clock kept above 1 MSPS
// R13: master clock 50 percent duty, low jitter
// R14: offset trimmed at 511 to 512
// R15: full scale trimmed at 1022 to 1023
// R16: complement equals binary with msb inverted
// R17: ten bit bus, bit nine msb
// R18: master clock falling edge starts sample
// R19: pipeline contents undefined until flushed
`timescale 1ns/1ns
`default_nettype none
module pao_converter
   import pao_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // link to capture logic
   pao_link_if.dev               link,
   // held analog level, full scale is 4096
   input  wire logic [RES_W-1:0] analog_in,
   // internal phases, for observation
   output logic                  sample_phase,
   output logic                  amplify_phase
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                                mclk_q;
      logic                                fmt_s1_q;
      logic                                fmt_s2_q;
      logic                                sample_ph_q;
      logic                                amplify_ph_q;
      logic [RES_W-1:0]                    hold_q;
      logic [NUM_RES_STAGES-1:0][RES_W-1:0] res_q;
      logic [NUM_STAGES-1:0][DL_W-1:0]      dl_q;
      logic [CODE_W-1:0]                   sync1_q;
      logic [CODE_W-1:0]                   out_q;
   } pao_dev_state_t;

   pao_dev_state_t s_q;
   pao_dev_state_t s_d;

   logic                                 mclk_fall;
   logic                                 mclk_rise;
   logic [NUM_RES_STAGES-1:0][RES_W-1:0] res_nx;
   logic [NUM_STAGES-1:0][DL_W-1:0]      dl_nx;
   logic [CODE_W:0]                      corr_sum;
   logic [CODE_W-1:0]                    corr_code;

   // R18: master clock fall is the sample command
   assign mclk_fall = s_q.mclk_q & ~link.mclk;
   assign mclk_rise = ~s_q.mclk_q & link.mclk;

   // ----------------------------------------------------------------
   // stages
   // ----------------------------------------------------------------
   // R3: nine two-bit stages then a one-bit stage
   genvar gi;
   generate
      for (gi = 0; gi < NUM_STAGES; gi++)
      begin : g_stage
         logic [RES_W-1:0]   r_in;
         logic [DL_W-1:0]    dl_in;
         logic [DIGIT_W-1:0] dig;
         logic [RES_W:0]     twice;
         logic [RES_W:0]     sub;

         if (gi == 0)
         begin : g_first
            assign r_in  = s_q.hold_q;
            assign dl_in = DL_RST;
         end
         else
         begin : g_next
            assign r_in  = s_q.res_q[gi-1];
            assign dl_in = s_q.dl_q[gi-1];
         end

         if (gi < NUM_RES_STAGES)
         begin : g_two_bit
            // decisions overlap so a stage error is absorbed later
            assign dig   = (r_in < THR_LOW)  ? 2'h0 :
                           (r_in < THR_HIGH) ? 2'h1 : 2'h2;
            assign twice = {r_in, 1'b0};
            assign sub   = (dig == 2'h0) ? 13'h0000 :
                           (dig == 2'h1) ? RES_HALF : RES_FS;
            assign res_nx[gi] = RES_W'(twice - sub);
         end
         else
         begin : g_one_bit
            assign dig   = {1'b0, (r_in >= THR_LAST)};
            assign twice = 13'h0000;
            assign sub   = 13'h0000;
         end

         // R5: stage result joins its sample's delay line slot
         always_comb
         begin
            dl_nx[gi]                          = dl_in;
            dl_nx[gi][gi*DIGIT_W +: DIGIT_W] = dig;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // correction
   // ----------------------------------------------------------------
   // R6: weighted sum of overlapping digits
   always_comb
   begin
      corr_sum = {1'b0, CODE_W'(0)};
      for (int i = 0; i < NUM_RES_STAGES; i++)
      begin
         corr_sum = corr_sum + ((CODE_W+1)'(s_q.dl_q[NUM_STAGES-1][i*DIGIT_W +: DIGIT_W])
                    << (NUM_RES_STAGES - 1 - i));
      end
      corr_sum = corr_sum
                 + (CODE_W+1)'(s_q.dl_q[NUM_STAGES-1][(NUM_STAGES-1)*DIGIT_W +: DIGIT_W]);
      // R10: select offset binary or two's complement
      // R16: complement is binary with msb inverted
      corr_code = corr_sum[CODE_W-1:0] ^ (s_q.fmt_s2_q ? FMT_FLIP : CODE_RST);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d          = s_q;
      s_d.mclk_q   = link.mclk;
      s_d.fmt_s1_q = link.data_format_select;
      s_d.fmt_s2_q = s_q.fmt_s1_q;

      // R1: one-cycle gap at every master clock change
      s_d.sample_ph_q  = link.mclk & s_q.mclk_q;
      s_d.amplify_ph_q = ~link.mclk & ~s_q.mclk_q;

      if (mclk_fall)
      begin
         // R2: input held at the end of the sample phase
         s_d.hold_q = analog_in;
         // R9: first of two cascaded output registers
         s_d.sync1_q = corr_code;
         // R7: second register lands the word on the seventh fall
         // R8: one word per master clock
         s_d.out_q = s_q.sync1_q;
      end

      // R4: even stages on rise, odd stages on fall
      for (int i = 0; i < NUM_STAGES; i++)
      begin
         if ((i % 2 == 0) ? mclk_rise : mclk_fall)
         begin
            s_d.dl_q[i] = dl_nx[i];
            if (i < NUM_RES_STAGES)
            begin
               s_d.res_q[i] = res_nx[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // R19: reset only fixes values, words stay invalid until flushed
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         // idle high like the master clock, so no false edge after reset
         s_q.mclk_q       <= 1'b1;
         s_q.fmt_s1_q     <= 1'b0;
         s_q.fmt_s2_q     <= 1'b0;
         s_q.sample_ph_q  <= 1'b0;
         s_q.amplify_ph_q <= 1'b0;
         s_q.hold_q       <= RES_RST;
         s_q.res_q        <= '0;
         s_q.dl_q         <= '0;
         s_q.sync1_q      <= CODE_RST;
         s_q.out_q        <= CODE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // R17: ten bit bus, bit nine most significant
   assign link.output_code = s_q.out_q;
   assign sample_phase     = s_q.sample_ph_q;
   assign amplify_phase    = s_q.amplify_ph_q;

endmodule
`default_nettype wire

//--- include/pao_pkg.sv
// Purpose: shared constants for the pipelined converter output logic
// Assumes: one 100 MHz system clock drives both ends
// Notes:   master clock is a divided copy of clk made by the capture end
package pao_pkg;

   // ----------------------------------------------------------------
   // system clock
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned CLK_HZ         = 100_000_000;

   // ----------------------------------------------------------------
   // converter core shape
   // ----------------------------------------------------------------
   localparam int unsigned NUM_STAGES     = 10;
   localparam int unsigned NUM_RES_STAGES = 9;
   localparam int unsigned DIGIT_W        = 2;
   localparam int unsigned CODE_W         = 10;
   localparam int unsigned RES_W          = 12;
   localparam int unsigned DL_W           = NUM_STAGES * DIGIT_W;

   // residue scale: full scale and stage decision levels
   localparam logic [RES_W:0]   RES_FS     = 13'h1000;
   localparam logic [RES_W:0]   RES_HALF   = 13'h0800;
   localparam logic [RES_W-1:0] THR_LOW    = 12'h600;
   localparam logic [RES_W-1:0] THR_HIGH   = 12'hA00;
   localparam logic [RES_W-1:0] THR_LAST   = 12'h800;

   // msb of the code, inverted for two's complement
   localparam int unsigned       CODE_MSB_POS = 9;
   localparam logic [CODE_W-1:0] FMT_FLIP     = 10'h200;

   // ----------------------------------------------------------------
   // timing in master clock cycles, minimum rate in samples per second
   // ----------------------------------------------------------------
   localparam int unsigned OUTPUT_LATENCY  = 7;
   localparam int unsigned INVALID_CYCLES  = 20;
   localparam int unsigned MIN_RATE_SPS    = 1_000_000;

   // master clock period in ns and its half in clk cycles
   localparam int unsigned MCLK_PERIOD_NS  = 40;
   localparam int unsigned MCLK_HALF_CYC   =
      (MCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
   localparam int unsigned MCLK_MAX_PERIOD_NS = 1_000_000_000 / MIN_RATE_SPS;
   localparam int unsigned HALF_CNT_W      = 8;
   localparam int unsigned WARM_CNT_W      = 5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
   localparam logic [RES_W-1:0]  RES_RST  = 12'h000;
   localparam logic [DL_W-1:0]   DL_RST   = 20'h00000;

endpackage

//--- include/pao_link_if.sv
// Purpose: pins between the converter and the word capture logic
// Assumes: both ends run on the same clk
// Notes:   all signals are plain one-way wires
`timescale 1ns/1ns
`default_nettype none
interface pao_link_if;
   import pao_pkg::*;

   logic              mclk;
   logic              data_format_select;
   logic [CODE_W-1:0] output_code;

   modport dev
   (
      input  mclk,
      input  data_format_select,
      output output_code
   );

   modport cap
   (
      output mclk,
      output data_format_select,
      input  output_code
   );
endinterface
`default_nettype wire

//--- hw/pao_capture.sv
// Purpose: makes the master clock and captures converter words
// Assumes: converter sits on the same clk
// Notes:   words are read at the master clock rise, mid cycle
`timescale 1ns/1ns
`default_nettype none
module pao_capture
   import pao_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // link to converter
   pao_link_if.cap                link,
   // user format choice, high for two's complement
   input  wire logic              fmt_sel,
   // captured words
   output logic                   word_valid,
   output logic [CODE_W-1:0]      word_data
);

   typedef enum logic [0:0] {
      PAO_WARMUP = 1'b0,
      PAO_RUN    = 1'b1
   } pao_cap_mode_t;

   typedef struct packed {
      pao_cap_mode_t           mode;
      logic [HALF_CNT_W-1:0]   half_cnt;
      logic                    mclk;
      logic                    fmt;
      logic [WARM_CNT_W-1:0]   warm_cnt;
      logic                    valid;
      logic [CODE_W-1:0]       data;
   } pao_cap_state_t;

   pao_cap_state_t c_q;
   pao_cap_state_t c_d;

   // R12: master clock period below the slowest allowed
   localparam int unsigned MCLK_OK = (MCLK_PERIOD_NS < MCLK_MAX_PERIOD_NS) ? 1 : 0;
   localparam logic [HALF_CNT_W-1:0] HALF_LAST =
      HALF_CNT_W'(MCLK_OK * MCLK_HALF_CYC - 1);
   localparam logic [WARM_CNT_W-1:0] WARM_LAST = WARM_CNT_W'(INVALID_CYCLES - 1);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      c_d       = c_q;
      c_d.valid = 1'b0;
      c_d.fmt   = fmt_sel;
      // R13: equal high and low halves
      if (c_q.half_cnt == HALF_LAST)
      begin
         c_d.half_cnt = '0;
         c_d.mclk     = ~c_q.mclk;
         if (c_q.mclk)
         begin
            // R11: count master clocks of invalid data
            case (c_q.mode)
               PAO_WARMUP:
               begin
                  c_d.warm_cnt = c_q.warm_cnt + 1'b1;
                  if (c_q.warm_cnt == WARM_LAST)
                  begin
                     c_d.mode = PAO_RUN;
                  end
               end
               PAO_RUN:
               begin
                  c_d.mode = PAO_RUN;
               end
               default:
               begin
                  c_d.mode = PAO_WARMUP;
               end
            endcase
         end
         else if (c_q.mode == PAO_RUN)
         begin
            // R11: words kept only after warm-up
            c_d.valid = 1'b1;
            c_d.data  = link.output_code;
         end
      end
      else
      begin
         c_d.half_cnt = c_q.half_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         c_q.mode     <= PAO_WARMUP;
         c_q.half_cnt <= '0;
         c_q.mclk     <= 1'b1;
         c_q.fmt      <= 1'b0;
         c_q.warm_cnt <= '0;
         c_q.valid    <= 1'b0;
         c_q.data     <= CODE_RST;
      end
      else
      begin
         c_q <= c_d;
      end
   end

   assign link.mclk               = c_q.mclk;
   assign link.data_format_select = c_q.fmt;
   assign word_valid              = c_q.valid;
   assign word_data               = c_q.data;

endmodule
`default_nettype wire

//--- test/pao_link_checker.sv
// Purpose: concurrent checks on the converter link
// Assumes: one clk domain, async active low reset
// Notes:   master clock half period is two clk cycles
`timescale 1ns/1ns
`default_nettype none
module pao_link_checker
   import pao_pkg::*;
(
   // clock and reset
   input wire logic              clk,
   input wire logic              rstn,
   // link signals
   input wire logic              mclk,
   input wire logic              data_format_select,
   input wire logic [CODE_W-1:0] output_code,
   // converter phases
   input wire logic              sample_phase,
   input wire logic              amplify_phase
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   phase_excl_a : assert property (!(sample_phase && amplify_phase))
      else $error("both phases high");
   sample_src_a : assert property (sample_phase |-> $past(mclk))
      else $error("sample phase while master clock low");
   amp_src_a : assert property (amplify_phase |-> !$past(mclk))
      else $error("amplify phase while master clock high");
   amp_follow_a : assert property ($fell(mclk) |-> ##[1:3] amplify_phase)
      else $error("no amplify phase after master clock fall");
   clk_duty_a : assert property ($fell(mclk) |=> !mclk ##1 mclk[*2] ##1 !mclk)
      else $error("master clock not two low two high");
   clk_rate_a : assert property ($rose(mclk) |=> mclk ##1 !mclk)
      else $error("master clock high phase wrong");
   code_step_a : assert property ($changed(output_code) |-> !$past(mclk) && $past(mclk, 2))
      else $error("output word changed off the sample edge");
   reset_code_a : assert property ($rose(rstn) |-> output_code == CODE_RST)
      else $error("output word not cleared by reset");

   fmt_seen_c : cover property ($rose(data_format_select));
endmodule
`default_nettype wire

//--- test/test_pipelined_adc_output_logic.sv
// Purpose: self-checking bench, converter facing capture logic
// Assumes: inputs driven at the falling clk edge
// Notes:   expected codes from an ideal residue model and code table
`timescale 1ns/1ns
`default_nettype none
module test_pipelined_adc_output_logic
   import pao_pkg::*;
;
   logic              clk;
   logic              rstn;
   logic [RES_W-1:0]  analog_in;
   logic              fmt_sel;
   logic              sample_phase;
   logic              amplify_phase;
   logic              word_valid;
   logic [CODE_W-1:0] word_data;
   int                err_total;
   int                checked;

   pao_link_if link_if ();
   pao_converter u_pao_converter (.clk(clk), .rstn(rstn), .link(link_if),
      .analog_in(analog_in), .sample_phase(sample_phase), .amplify_phase(amplify_phase));
   pao_capture u_pao_capture (.clk(clk), .rstn(rstn), .link(link_if), .fmt_sel(fmt_sel),
      .word_valid(word_valid), .word_data(word_data));
   pao_link_checker u_pao_link_checker (.clk(clk), .rstn(rstn), .mclk(link_if.mclk),
      .data_format_select(link_if.data_format_select), .output_code(link_if.output_code),
      .sample_phase(sample_phase), .amplify_phase(amplify_phase));

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [CODE_W-1:0] ideal(input int a);
      int r;
      int d;
      int c;
      r = a;
      c = 0;
      for (int i = 0; i < 9; i++)
      begin
         d = (r < 32'h600) ? 0 : ((r < 32'hA00) ? 1 : 2);
         c = c * 2 + d;
         r = 2 * r - d * 32'h800;
      end
      c = c + ((r >= 32'h800) ? 1 : 0);
      return c[CODE_W-1:0];
   endfunction

   task automatic chk(input string what, input logic [CODE_W-1:0] seen,
                      input logic [CODE_W-1:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      if (err_total == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic hang(input string what);
      err_total++;
      $display("Error %s expected event seen timeout", what);
      end_sim();
   endtask

   // returns at the negedge just after the master clock fell
   task automatic wait_fall();
      logic p;
      p = link_if.mclk;
      for (int k = 0; k < 8; k++)
      begin
         @(negedge clk);
         if (p === 1'b1 && link_if.mclk === 1'b0)
            return;
         p = link_if.mclk;
      end
      hang("master clock fall");
   endtask

   task automatic wait_valid();
      for (int k = 0; k < 8; k++)
      begin
         @(negedge clk);
         if (word_valid === 1'b1)
            return;
      end
      hang("word valid");
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rstn = 1'b0;
      repeat (4) @(negedge clk);
      chk("reset code", link_if.output_code, CODE_RST);
      chk("reset valid", {9'h000, word_valid}, 10'h000);
      rstn = 1'b1;
   endtask

   task automatic t_warmup();
      logic p;
      int   f;
      p = 1'b1;
      f = 0;
      for (int k = 0; k < 200 && word_valid !== 1'b1; k++)
      begin
         @(negedge clk);
         if (p === 1'b1 && link_if.mclk === 1'b0)
            f++;
         p = link_if.mclk;
      end
      if (word_valid !== 1'b1)
         hang("first word valid");
      chk("first valid", {9'h000, word_valid}, 10'h001);
      chk("falls before valid", f[CODE_W-1:0], 10'h014);
      @(negedge clk);
      chk("valid pulse end", {9'h000, word_valid}, 10'h000);
   endtask

   // new sample every fall, word of fall j-7 seen after fall j
   task automatic t_stream();
      logic [RES_W-1:0] vals [10];
      logic [RES_W-1:0] hold;
      vals = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h123,
               12'hABC, 12'h600, 12'h5FF, 12'hA00, 12'h9FF};
      fmt_sel = 1'b0;
      hold = analog_in;
      for (int j = 0; j < 17; j++)
      begin
         wait_fall();
         if (j < 10)
            analog_in = vals[j];
         @(negedge clk);
         if (j >= 7)
            chk("stream code", link_if.output_code, ideal(vals[j-7]));
         else
            chk("stream hold", link_if.output_code, ideal(hold));
      end
   endtask

   task automatic t_format();
      logic [RES_W-1:0]  vin [4];
      logic [CODE_W-1:0] vout [4];
      logic [CODE_W-1:0] e;
      vin = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
      vout = '{10'h000, 10'h1FF, 10'h200, 10'h3FF};
      for (int f = 0; f < 2; f++)
         for (int i = 0; i < 4; i++)
         begin
            fmt_sel = f[0];
            analog_in = vin[i];
            e = vout[i] ^ (f[0] ? FMT_FLIP : CODE_RST);
            repeat (10) wait_fall();
            @(negedge clk);
            chk("format code", link_if.output_code, e);
            wait_valid();
            chk("captured word", word_data, e);
         end
   endtask

   // offset and full-scale trim points, offset binary
   task automatic t_trim();
      logic [RES_W-1:0]  tin [4];
      logic [CODE_W-1:0] tout [4];
      tin  = '{12'h7FF, 12'h800, 12'hFFB, 12'hFFC};
      tout = '{10'h1FF, 10'h200, 10'h3FE, 10'h3FF};
      fmt_sel = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         analog_in = tin[i];
         repeat (10) wait_fall();
         @(negedge clk);
         if (i < 2)
            chk("offset trim code", link_if.output_code, tout[i]);
         else
            chk("full scale trim code", link_if.output_code, tout[i]);
      end
   endtask

   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      analog_in = 12'h800;
      fmt_sel = 1'b0;
      err_total = 0;
      checked = 0;
      t_reset();
      t_warmup();
      t_stream();
      t_format();
      t_trim();
      t_reset();
      t_warmup();
      end_sim();
   end
endmodule
`default_nettype wire
